// ### src/erp_top.v
/*
  Error report pin logic of one memory channel: parity and write checksum
  reports delayed by programmed latencies, severity by a fixed delay, all driven as a
  three-level symbol, one slow-clock cycle each; pin float control.
  Assumes check results arrive in slow_tick cycles, inputs synchronous.
*/
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "erp_map.vh"
module erp_top (
  input wire sys_clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_r,
  input wire par_bad,
  input wire wchk_valid,
  input wire wchk_bad,
  input wire rd_cmd,
  input wire rd_severe,
  input wire sleep,
  output reg slow_tick_r,
  output reg [1:0] err_sym_r,
  output reg err_oe_r,
  output reg extra_lane_oe_r,
  output reg irq_r
);

  localparam [31:0] MODSET_LOAD = `ERP_MODSET_CYC;
  localparam [31:0] PDDIS_LOAD = `ERP_PDDIS_CYC;
  localparam [31:0] VARLAT = `ERP_VARLAT_CYC;
  localparam [31:0] SEVDLY = `ERP_SEVDLY_CYC;

  // Pin drive states, one-hot
  localparam [2:0] ST_FLOAT = 3'h1;
  localparam [2:0] ST_DRIVE = 3'h2;
  localparam [2:0] ST_DRAIN = 3'h4;

  reg [11:0] mr2_r;
  reg [11:0] mr5_r;
  reg [11:0] mode_register_fifteen_r;
  reg [5:0] feat_r;
  reg [3:0] status_r;
  reg [3:0] status_nxt;
  reg [3:0] mask_r;
  reg [1:0] div_r;
  reg [2:0] pin_st_r;
  reg [2:0] pin_st_nxt;
  reg sleep_d_r;
  reg sleep_float_r;
  reg feat_act_d_r;
  wire [1:0] sym_nxt;
  reg [31:0] rdata_nxt;

  wire par_en;
  wire wchk_en;
  wire sev_mode;
  wire feat_act;
  wire [3:0] plat_field;
  wire [3:0] plat;
  wire [4:0] wlat;
  wire par_due;
  wire wchk_due;
  wire sev_due;
  wire mod_busy;
  wire mod_done;
  wire pd_done;
  wire wr_status;

  // Slow-clock enable: one sys_clk pulse every four cycles
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_r <= 2'h0;
      slow_tick_r <= 1'b0;
    end
    else
    begin
      div_r <= div_r + 2'h1;
      slow_tick_r <= (div_r == 2'h3);
    end
  end

  // Feature decode from mode and feature registers
  assign par_en = mode_register_fifteen_r[`ERP_MODE_REGISTER_FIFTEEN_PAR_EN];
  assign wchk_en = feat_r[`ERP_FEAT_WCHK];
  assign sev_mode = mr5_r[`ERP_MR5_SEVPIN]
    & feat_r[`ERP_FEAT_TWOLVL] & ~feat_r[`ERP_FEAT_WCHK]
    & ~feat_r[`ERP_FEAT_RCHK] & ~feat_r[`ERP_FEAT_POISON]
    & feat_r[`ERP_FEAT_SEV];
  assign feat_act = par_en | wchk_en | sev_mode
    | feat_r[`ERP_FEAT_CSPFB];

  // Latencies in slow cycles
  assign plat_field = mode_register_fifteen_r[`ERP_MODE_REGISTER_FIFTEEN_PLAT_HI:`ERP_MODE_REGISTER_FIFTEEN_PLAT_LO];
  assign plat = (plat_field == 4'h0) ? VARLAT[3:0]
    : plat_field;
  assign wlat = mr2_r[`ERP_MR2_WLAT_HI:`ERP_MR2_WLAT_LO];

  // Parity outcome enters every slow cycle while checking is on
  erp_delay #(
    .DEPTH(16),
    .LW(4)
  ) u_par_dly (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .shift_en(slow_tick_r),
    .din(par_en & par_bad),
    .lat(plat),
    .dout(par_due)
  );

  // Write burst outcome; a zero field is treated as one cycle
  erp_delay #(
    .DEPTH(32),
    .LW(5)
  ) u_wchk_dly (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .shift_en(slow_tick_r),
    .din(wchk_en & wchk_valid & wchk_bad),
    .lat((wlat == 5'h00) ? 5'h01 : wlat),
    .dout(wchk_due)
  );

  // Read severity with fixed report delay
  erp_delay #(
    .DEPTH(16),
    .LW(4)
  ) u_sev_dly (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .shift_en(slow_tick_r),
    .din(sev_mode & rd_cmd & rd_severe),
    .lat(SEVDLY[3:0]),
    .dout(sev_due)
  );

  // Mode-set delay after the last pin user goes away
  erp_timer u_mod_tmr (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start(feat_act_d_r & ~feat_act),
    .cancel(feat_act),
    .load(MODSET_LOAD[7:0]),
    .busy(mod_busy),
    .done(mod_done)
  );

  // Power-down disable delay after sleep entry
  erp_timer u_pd_tmr (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start(sleep & ~sleep_d_r),
    .cancel(~sleep),
    .load(PDDIS_LOAD[7:0]),
    .busy(),
    .done(pd_done)
  );

  // Sleep float flag, held until sleep ends
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sleep_d_r <= 1'b0;
      feat_act_d_r <= 1'b0;
      sleep_float_r <= 1'b0;
    end
    else
    begin
      sleep_d_r <= sleep;
      feat_act_d_r <= feat_act;
      if (!sleep)
        sleep_float_r <= 1'b0;
      else if (pd_done)
        sleep_float_r <= 1'b1;
    end
  end

  // Pin drive state machine
  always @*
  begin
    pin_st_nxt = pin_st_r;
    case (pin_st_r)
      ST_FLOAT:
        if (feat_act && !sleep_float_r)
          pin_st_nxt = ST_DRIVE;
      ST_DRIVE:
        if (sleep_float_r)
          pin_st_nxt = ST_FLOAT;
        else if (!feat_act)
          pin_st_nxt = ST_DRAIN;
      ST_DRAIN:
        if (sleep_float_r)
          pin_st_nxt = ST_FLOAT;
        else if (feat_act)
          pin_st_nxt = ST_DRIVE;
        else if (mod_done || !mod_busy)
          pin_st_nxt = ST_FLOAT;
      default:
        pin_st_nxt = ST_FLOAT;
    endcase
  end

  // Symbol select: parity outranks write check and severity
  assign sym_nxt = par_due ? `ERP_SYM_PAR
    : (wchk_due || sev_due) ? `ERP_SYM_WCHK
    : `ERP_SYM_NOERR;

  // Pin outputs; symbol changes only on slow ticks so it spans one
  // slow cycle, and it keeps following the delay lines while the pin floats
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_st_r <= ST_FLOAT;
      err_sym_r <= `ERP_SYM_NOERR;
      err_oe_r <= 1'b0;
      extra_lane_oe_r <= 1'b1;
    end
    else
    begin
      pin_st_r <= pin_st_nxt;
      err_oe_r <= (pin_st_nxt != ST_FLOAT);
      extra_lane_oe_r <= mr5_r[`ERP_MR5_LANE_ON];
      if (slow_tick_r)
        err_sym_r <= sym_nxt;
    end
  end

  // Register writes
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mr2_r <= `ERP_MR2_RST;
      mr5_r <= `ERP_MR5_RST;
      mode_register_fifteen_r <= `ERP_MODE_REGISTER_FIFTEEN_RST;
      feat_r <= `ERP_FEAT_RST;
      mask_r <= 4'h0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ERP_OFS_MR2: mr2_r <= reg_wdata[11:0];
        `ERP_OFS_MR5: mr5_r <= reg_wdata[11:0];
        `ERP_OFS_MODE_REGISTER_FIFTEEN: mode_register_fifteen_r <= reg_wdata[11:0];
        `ERP_OFS_FEAT: feat_r <= reg_wdata[5:0];
        `ERP_OFS_MASK: mask_r <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // Sticky status: write one clears, a new event in the same cycle wins
  assign wr_status = reg_wr && (reg_addr == `ERP_OFS_STATUS);

  always @*
  begin
    status_nxt = status_r;
    if (wr_status)
      status_nxt = status_r & ~reg_wdata[3:0];
    if (slow_tick_r && par_due)
      status_nxt[`ERP_ST_PAR] = 1'b1;
    if (slow_tick_r && wchk_due)
      status_nxt[`ERP_ST_WCHK] = 1'b1;
    if (slow_tick_r && sev_due)
      status_nxt[`ERP_ST_SEV] = 1'b1;
    if (err_oe_r && pin_st_nxt == ST_FLOAT)
      status_nxt[`ERP_ST_FLOAT] = 1'b1;
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_r <= 4'h0;
      irq_r <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_r);
    end
  end

  // Read mux; unmapped addresses read zero. State bit 8 tells the host
  // that severity on the error pin is supported, to be read before use
  always @*
  begin
    case (reg_addr)
      `ERP_OFS_MR2: rdata_nxt = {20'h00000, mr2_r};
      `ERP_OFS_MR5: rdata_nxt = {20'h00000, mr5_r};
      `ERP_OFS_MODE_REGISTER_FIFTEEN: rdata_nxt = {20'h00000, mode_register_fifteen_r};
      `ERP_OFS_FEAT: rdata_nxt = {26'h0000000, feat_r};
      `ERP_OFS_STATUS: rdata_nxt = {28'h0000000, status_r};
      `ERP_OFS_MASK: rdata_nxt = {28'h0000000, mask_r};
      `ERP_OFS_STATE: rdata_nxt = {23'h000000, 1'h1, sleep_float_r, sev_mode,
        feat_act, pin_st_r, err_sym_r};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata_r <= 32'h00000000;
    else
      reg_rdata_r <= reg_rd ? rdata_nxt : 32'h00000000;
  end

endmodule

// ### include/erp_map.vh
/*
  Constants for the error report pin block: register offsets, field
  positions, reset values, pin symbols and timing counts.
  Assumes a 250 MHz sys_clk and a slow clock of four sys_clk cycles.
*/
`ifndef ERP_MAP_VH
`define ERP_MAP_VH

// Register byte offsets
`define ERP_OFS_MR2        8'h00
`define ERP_OFS_MR5        8'h04
`define ERP_OFS_MODE_REGISTER_FIFTEEN       8'h08
`define ERP_OFS_FEAT       8'h0C
`define ERP_OFS_STATUS     8'h10
`define ERP_OFS_MASK       8'h14
`define ERP_OFS_STATE      8'h18

// Mode register fields (12-bit operand words)
`define ERP_MR2_WLAT_HI    11
`define ERP_MR2_WLAT_LO    7
`define ERP_MR5_SEVPIN     9
`define ERP_MR5_LANE_ON    10
`define ERP_MODE_REGISTER_FIFTEEN_PAR_EN    0
`define ERP_MODE_REGISTER_FIFTEEN_PLAT_HI   11
`define ERP_MODE_REGISTER_FIFTEEN_PLAT_LO   8

// Feature register bits
`define ERP_FEAT_WCHK      0
`define ERP_FEAT_RCHK      1
`define ERP_FEAT_POISON    2
`define ERP_FEAT_SEV       3
`define ERP_FEAT_CSPFB     4
`define ERP_FEAT_TWOLVL    5

// Status and mask bits
`define ERP_ST_PAR         0
`define ERP_ST_WCHK        1
`define ERP_ST_SEV         2
`define ERP_ST_FLOAT       3

// Reset values
`define ERP_MR2_RST        12'h000
`define ERP_MR5_RST        12'h400
`define ERP_MODE_REGISTER_FIFTEEN_RST       12'h000
`define ERP_FEAT_RST       6'h20

// Pin symbols, two-bit binary form of the three levels
`define ERP_SYM_NOERR      2'h3
`define ERP_SYM_WCHK       2'h1
`define ERP_SYM_PAR        2'h0

// Timing
`define ERP_CK4_DIV        4
`define ERP_SYS_NS         4
`define ERP_SLOW_NS        (`ERP_SYS_NS * `ERP_CK4_DIV)
`define ERP_INTPATH_NS     12
`define ERP_VARLAT_CYC     ((`ERP_INTPATH_NS + `ERP_SLOW_NS - 1) / `ERP_SLOW_NS)
`define ERP_SEVDLY_CYC     8
`define ERP_MODSET_NS      30
`define ERP_MODSET_CYC     ((`ERP_MODSET_NS + `ERP_SYS_NS - 1) / `ERP_SYS_NS)
`define ERP_PDDIS_NS       20
`define ERP_PDDIS_CYC      ((`ERP_PDDIS_NS + `ERP_SYS_NS - 1) / `ERP_SYS_NS)

`endif

// ### src/erp_delay.v
/*
  Programmable delay line: a shift register that advances on each
  slow-clock enable and taps out the stage picked by lat (1..DEPTH).
  Assumes the caller never presents lat of zero.
*/
`timescale 1ns/100ps
module erp_delay #(
  parameter DEPTH = 32,
  parameter LW = 5
) (
  input wire sys_clk,
  input wire rst_b,
  input wire shift_en,
  input wire din,
  input wire [LW-1:0] lat,
  output wire dout
);

  reg [DEPTH-1:0] stage_r;
  wire [LW-1:0] tap;

  // Tap index is one less than the latency
  assign tap = lat - {{(LW-1){1'b0}}, 1'b1};
  assign dout = stage_r[tap];

  // One flop per stage, all advancing together
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_stage
      always @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
          stage_r[i] <= 1'b0;
        else if (shift_en)
          stage_r[i] <= (i == 0) ? din : stage_r[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate

endmodule

// ### src/erp_timer.v
/*
  One-shot down counter in sys_clk cycles; busy while running, done
  pulses for one cycle on expiry. A start while busy reloads it.
  Assumes load is at least one.
*/
`timescale 1ns/100ps
module erp_timer (
  input wire sys_clk,
  input wire rst_b,
  input wire start,
  input wire cancel,
  input wire [7:0] load,
  output wire busy,
  output reg done
);

  reg [7:0] count_r;

  assign busy = (count_r != 8'h00);

  // Count down; cancel wins so a re-enabled feature keeps the pin
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_r <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (cancel)
        count_r <= 8'h00;
      else if (start)
        count_r <= load;
      else if (busy)
      begin
        count_r <= count_r - 8'h01;
        if (count_r == 8'h01)
          done <= 1'b1;
      end
    end
  end

endmodule

// ### verif/erp_monitor.sv
/* Port checker for the error report pin block.
   Assumes one clock domain and erp_map.vh on the include path. */
`timescale 1ns/100ps
`include "erp_map.vh"
module erp_monitor (
  input wire sys_clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata_r,
  input wire sleep,
  input wire slow_tick_r,
  input wire [1:0] err_sym_r,
  input wire err_oe_r,
  input wire extra_lane_oe_r
);
  reg [7:0] wr_age_r;
  reg any_wr_r;
  reg lane_r;
  // Write age saturates so idle stretches never wrap
  always @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      wr_age_r <= 8'hFF;
      any_wr_r <= 1'b0;
      lane_r <= 1'b1;
    end
    else
    begin
      wr_age_r <= reg_wr ? 8'h00 : wr_age_r + {7'h0, wr_age_r != 8'hFF};
      any_wr_r <= any_wr_r | reg_wr;
      if (reg_wr && reg_addr == `ERP_OFS_MR5)
        lane_r <= reg_wdata[`ERP_MR5_LANE_ON];
    end
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence tick_gap;
    !slow_tick_r [*3] ##1 slow_tick_r;
  endsequence
  sequence sleep_held;
    sleep [*8];
  endsequence
  // Symbols change only at slow ticks, one slow cycle apart
  tick_period_a: assert property (slow_tick_r |=> tick_gap)
    else $error("slow tick spacing wrong");
  sym_change_a: assert property ($changed(err_sym_r) |-> $past(slow_tick_r))
    else $error("symbol changed off a tick");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_r == 32'h0)
    else $error("read data outside answer cycle");
  unmapped_rd_a: assert property (reg_rd && reg_addr > `ERP_OFS_STATE
    |=> reg_rdata_r == 32'h0)
    else $error("unmapped read not zero");
  lane_follow_a: assert property (reg_wr && reg_addr == `ERP_OFS_MR5
    |-> ##2 extra_lane_oe_r == lane_r)
    else $error("extra lane enable wrong");
  sleep_float_a: assert property (sleep_held |=> !err_oe_r)
    else $error("pin driven in sleep");
  early_float_a: assert property ($fell(err_oe_r)
    |-> sleep || wr_age_r >= 8'h08)
    else $error("pin floated too early");
  idle_float_a: assert property (!any_wr_r |-> !err_oe_r)
    else $error("pin driven with features off");
endmodule

// ### verif/erp_host_model.sv
/* Host side receiver of the error pin: one sample per slow cycle.
   Assumes the pin levels arrive as the binary symbol form. */
`timescale 1ns/100ps
`include "erp_map.vh"
module erp_host_model (
  input wire sys_clk,
  input wire rst_b,
  input wire slow_tick_r,
  input wire [1:0] err_sym_r,
  input wire err_oe_r,
  output reg [15:0] tick_cnt_r,
  output reg rx_v_r,
  output reg [17:0] rx_w_r
);
  // A floated pin carries nothing, so only driven error levels count
  always @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      tick_cnt_r <= 16'h0;
      rx_v_r <= 1'b0;
      rx_w_r <= 18'h0;
    end
    else if (slow_tick_r)
    begin
      tick_cnt_r <= tick_cnt_r + 16'h1;
      rx_v_r <= err_oe_r && err_sym_r != `ERP_SYM_NOERR;
      rx_w_r <= {tick_cnt_r, err_sym_r};
    end
    else
      rx_v_r <= 1'b0;
endmodule

// ### verif/test_error_pin_reporting.sv
/* Self-checking bench for the error report pin block.
   Assumes the host model and checker files are compiled first. */
`timescale 1ns/100ps
`include "erp_map.vh"
module test_error_pin_reporting;
  reg sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg par_bad = 0, wchk_valid = 0, wchk_bad = 0, rd_cmd = 0;
  reg rd_severe = 0, sleep = 0;
  wire [31:0] reg_rdata_r;
  wire slow_tick_r, err_oe_r, extra_lane_oe_r, irq_r;
  wire [1:0] err_sym_r;
  logic [31:0] rq[$], sq[$];
  integer n_fail = 0, check_count = 0, cyc = 0, seed = 69;
  reg [3:0] m;
  erp_top erp_top_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .par_bad(par_bad),
    .wchk_valid(wchk_valid), .wchk_bad(wchk_bad), .rd_cmd(rd_cmd),
    .rd_severe(rd_severe), .sleep(sleep), .slow_tick_r(slow_tick_r),
    .err_sym_r(err_sym_r), .err_oe_r(err_oe_r),
    .extra_lane_oe_r(extra_lane_oe_r), .irq_r(irq_r));
  erp_host_model host_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .slow_tick_r(slow_tick_r), .err_sym_r(err_sym_r),
    .err_oe_r(err_oe_r), .tick_cnt_r(), .rx_v_r(), .rx_w_r());
  always #2 sys_clk = ~sys_clk;
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        $display("[ERR] %0t got %h exp %h", $time, g, e);
        n_fail = n_fail + 1;
      end
    end
  endtask
  task report_and_stop;
    begin
      if (n_fail == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge sys_clk);
      reg_rd <= 1; reg_addr <= a; rq.push_back(e);
      @(posedge sys_clk);
      reg_rd <= 0;
    end
  endtask
  // Returns just after an edge that sampled the slow tick
  task to_tick;
    do @(posedge sys_clk); while (slow_tick_r !== 1'b1);
  endtask
  // k: bit0 parity, bit1 write check, bit2 severe read; l latency
  task inj(input [2:0] k, input [15:0] l, input [1:0] s);
    begin
      to_tick;
      sq.push_back({host_inst.tick_cnt_r + l + 16'h2, s});
      par_bad <= k[0]; wchk_valid <= k[1]; wchk_bad <= k[1];
      rd_cmd <= k[2]; rd_severe <= k[2];
      to_tick;
      {par_bad, wchk_valid, wchk_bad, rd_cmd, rd_severe} <= 5'h0;
      repeat (10) to_tick;
    end
  endtask
  // Results are matched in arrival order against the noted ones
  always @(posedge sys_clk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
      chk(reg_rdata_r, rq.pop_front());
    if (host_inst.rx_v_r)
      chk(host_inst.rx_w_r, sq.pop_front());
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1;
    rd(`ERP_OFS_MR2, 32'h0);
    rd(`ERP_OFS_MR5, 32'h400);
    rd(`ERP_OFS_FEAT, 32'h20);
    rd(8'h1C, 32'h0);
    chk(err_oe_r, 1'b0);
    wr(`ERP_OFS_MODE_REGISTER_FIFTEEN, 32'h201);
    inj(3'h1, 16'h2, `ERP_SYM_PAR);
    chk(err_oe_r, 1'b1);
    wr(`ERP_OFS_MODE_REGISTER_FIFTEEN, 32'h001);
    inj(3'h1, 16'h1, `ERP_SYM_PAR);
    wr(`ERP_OFS_MR2, 32'h180);
    wr(`ERP_OFS_FEAT, 32'h21);
    inj(3'h2, 16'h3, `ERP_SYM_WCHK);
    wr(`ERP_OFS_MODE_REGISTER_FIFTEEN, 32'h301);
    inj(3'h3, 16'h3, `ERP_SYM_PAR);
    rd(`ERP_OFS_STATUS, 32'h3);
    m = $random(seed);
    wr(`ERP_OFS_MASK, {28'h0, m});
    repeat (3) @(posedge sys_clk);
    chk(irq_r, |m[1:0]);
    wr(`ERP_OFS_STATUS, 32'h3);
    repeat (3) @(posedge sys_clk);
    chk(irq_r, 1'b0);
    wr(`ERP_OFS_MODE_REGISTER_FIFTEEN, 32'h0);
    rd(`ERP_OFS_STATE, 32'h12B);
    wr(`ERP_OFS_MR5, 32'h200);
    wr(`ERP_OFS_FEAT, 32'h28);
    repeat (3) @(posedge sys_clk);
    chk(extra_lane_oe_r, 1'b0);
    inj(3'h4, 16'h8, `ERP_SYM_WCHK);
    wr(`ERP_OFS_FEAT, 32'h20);
    repeat (7) @(posedge sys_clk);
    chk(err_oe_r, 1'b1);
    repeat (6) @(posedge sys_clk);
    chk(err_oe_r, 1'b0);
    rd(`ERP_OFS_STATUS, 32'hC);
    // Start-point feedback alone keeps the pin; read check blocks severity
    wr(`ERP_OFS_FEAT, 32'h3A);
    repeat (3) @(posedge sys_clk);
    chk(err_oe_r, 1'b1);
    rd(`ERP_OFS_STATE, 32'h12B);
    wr(`ERP_OFS_MODE_REGISTER_FIFTEEN, 32'h001);
    repeat (4) @(posedge sys_clk);
    sleep <= 1;
    repeat (9) @(posedge sys_clk);
    chk(err_oe_r, 1'b0);
    sleep <= 0;
    repeat (4) @(posedge sys_clk);
    chk(err_oe_r, 1'b1);
    chk(rq.size() + sq.size(), 32'h0);
    report_and_stop;
  end
endmodule
bind erp_top erp_monitor erp_monitor_inst (.sys_clk(sys_clk),
  .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
  .sleep(sleep), .slow_tick_r(slow_tick_r), .err_sym_r(err_sym_r),
  .err_oe_r(err_oe_r), .extra_lane_oe_r(extra_lane_oe_r));
